// >>> core/rdiag_pkg.sv
// package for the remote discrete i/o diagnostic and address display block
// assumes a single 10 MHz clock domain and synchronous active-high reset
`default_nettype none
package rdiag_pkg;
  // diagnostic bit positions (absolute bit numbers of the status image)
  localparam int unsigned RDIAG_BIT_ERR_APPEAR   = 16;
  localparam int unsigned RDIAG_BIT_ERR_GONE     = 17;
  localparam int unsigned RDIAG_BIT_RESTART      = 35;
  localparam int unsigned RDIAG_BIT_COLDSTART    = 36;
  localparam int unsigned RDIAG_BIT_MAINT        = 37;
  localparam int unsigned RDIAG_BIT_IDENT_VIOL   = 39;
  localparam int unsigned RDIAG_BIT_EXT_AVAIL    = 55;
  localparam int unsigned RDIAG_BIT_TB_OOS       = 56;
  localparam int unsigned RDIAG_BIT_FLB_ACTIVE   = 57;
  localparam int unsigned RDIAG_BIT_FLB_ERR      = 58;
  localparam int unsigned RDIAG_BIT_PSU_IN       = 59;
  localparam int unsigned RDIAG_BIT_PSU_OUT      = 60;
  localparam int unsigned RDIAG_BIT_ADDR_JMP     = 61;
  localparam int unsigned RDIAG_BIT_WR_LOCK      = 63;
  localparam int unsigned RDIAG_BIT_BI_SIM       = 64;
  localparam int unsigned RDIAG_BIT_BI_FSAFE     = 72;
  localparam int unsigned RDIAG_BIT_BO_FSAFE     = 80;
  localparam int unsigned RDIAG_BIT_BO_SIM       = 84;
  localparam int unsigned RDIAG_BIT_BI_OOS       = 88;
  localparam int unsigned RDIAG_BIT_BO_OOS       = 96;
  // image spans bytes 2..12 (bits 16..103); first byte index of the image
  localparam int unsigned RDIAG_FIRST_BYTE       = 2;
  localparam int unsigned RDIAG_NUM_BYTES        = 11;
  localparam int unsigned RDIAG_IMG_BITS         = 104;
  // status length byte values
  localparam logic [7:0]  RDIAG_LEN_STD          = 8'h08;
  localparam logic [7:0]  RDIAG_LEN_EXT          = 8'h0e;
  // identifier save time
  localparam int unsigned RDIAG_SAVE_MS          = 5000;
  localparam int unsigned RDIAG_CLK_KHZ          = 10000;
  localparam int unsigned RDIAG_SAVE_CYC         = RDIAG_SAVE_MS * RDIAG_CLK_KHZ;
  // reset values
  localparam logic [7:0]  RDIAG_DOUT_RST         = 8'h00;

  // identifier selection
  typedef enum logic {RDIAG_ID_PROFILE, RDIAG_ID_MANUF} rdiag_id_e;

  // level conditions from the function blocks
  typedef struct packed {
    logic        restart;
    logic        coldstart;
    logic        maint_req;
    logic        ident_viol;
    logic        tb_oos;
    logic        flb_active;
    logic        flb_err;
    logic        psu_in_fail;
    logic        psu_out_fail;
    logic        addr_jumper;
    logic        wr_lock;
    logic [15:0] bi_sim;
    logic [15:0] bi_fsafe;
    logic [15:0] bi_oos;
    logic [7:0]  bo_sim;
    logic [7:0]  bo_fsafe;
    logic [7:0]  bo_oos;
  } rdiag_cond_s;
endpackage : rdiag_pkg
`default_nettype wire

// >>> core/rdiag_img_mem.sv
// small byte-wide read memory holding the packed diagnostic image
// assumes writes and reads on the same clock; read data is registered
`default_nettype none
module rdiag_img_mem #(
  parameter int unsigned NBYTES = 11
) (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [NBYTES*8-1:0]       img,
  input  wire logic [$clog2(NBYTES)-1:0] rd_idx,
  output logic      [7:0]                rd_data
);
  logic [7:0] mem_q [NBYTES];

  // refresh every byte each cycle so the read view tracks the levels
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NBYTES; i++)
    begin
      mem_q[i] <= sys_rst ? 8'h00 : img[i*8 +: 8];
    end
  end

  // registered read port; out of range reads give zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rd_data <= 8'h00;
    else if (32'(rd_idx) < NBYTES)
      rd_data <= mem_q[rd_idx];
    else
      rd_data <= 8'h00;
  end
endmodule : rdiag_img_mem
`default_nettype wire

// >>> core/rdiag_top.sv
// diagnostic image builder and power-up address display for a remote i/o unit
// assumes condition levels and control inputs from same-clock logic, jumper from a pin
//
// How it works
// - restart, coldstart, maintenance, ident violation at bits 35,36,37,39.
// - bits 38, 40..54 and 62 always read zero.
// - bit 55 set to announce extended bytes follow.
// - bits 56,57,58: transducer oos, logic block active, logic block error.
// - bits 59 and 60: input and output supply failures.
// - bit 61 address jumper active, bit 63 write locked.
// - bits 64..71: simulation in input block pair k.
// - bits 72..79: fail-safe in input block pair k.
// - bits 80..83: fail-safe in output block pair k.
// - bits 84..87: simulation in output block pair k.
// - bits 88..95: input block pair k out of service.
// - bits 96..103: each output block out of service alone.
// - power-up with jumper: address on outputs 1..7, lsb on output 1.
// - output 8 on for manufacturer identifier, off for profile.
// - identifier change saved over 5 s, applied after power cycle.
// - profile identifier vs manufacturer master: acyclic ok, cyclic refused.
// - bit 55 is msb of byte 6; length becomes 0e not 08.
// - bit 16 pulses on error appearing, bit 17 on disappearing.
`default_nettype none
module rdiag_top (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire rdiag_pkg::rdiag_cond_s cond,
  input  wire logic                   sim_jumper_pin,
  input  wire logic [6:0]             node_addr,
  input  wire logic                   id_sel_req,
  input  wire logic                   init_done,
  input  wire logic [3:0]             diag_rd_idx,
  input  wire logic                   master_manuf_id,
  input  wire logic                   cyc_req,
  input  wire logic                   acyc_req,
  input  wire logic [7:0]             dout_app,
  output logic      [7:0]             dout,
  output logic      [103:0]           diag_img,
  output logic      [7:0]             diag_byte,
  output logic      [7:0]             status_len,
  output logic                        id_active,
  output logic                        id_saving,
  output logic                        cyc_grant,
  output logic                        acyc_grant
);
  import rdiag_pkg::*;

  // or of adjacent block pairs, used for three input and two output groups
  function automatic logic [7:0] pair_or16(input logic [15:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++)
      r[k] = v[2*k] | v[2*k+1];
    return r;
  endfunction : pair_or16

  function automatic logic [3:0] pair_or8(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 4; k++)
      r[k] = v[2*k] | v[2*k+1];
    return r;
  endfunction : pair_or8

  // jumper comes from a pin: two flops before use
  logic jmp_m_q;
  logic jmp_q;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      jmp_m_q <= 1'b0;
      jmp_q   <= 1'b0;
    end
    else
    begin
      jmp_m_q <= sim_jumper_pin;
      jmp_q   <= jmp_m_q;
    end
  end

  // combinational image of level flags, unused bits stay zero
  logic [103:0] img_d;
  logic         any_err;
  always_comb
  begin
    img_d = '0;
    img_d[RDIAG_BIT_RESTART]    = cond.restart;
    img_d[RDIAG_BIT_COLDSTART]  = cond.coldstart;
    img_d[RDIAG_BIT_MAINT]      = cond.maint_req;
    img_d[RDIAG_BIT_IDENT_VIOL] = cond.ident_viol;
    img_d[RDIAG_BIT_EXT_AVAIL]  = 1'b1;
    img_d[RDIAG_BIT_TB_OOS]     = cond.tb_oos;
    img_d[RDIAG_BIT_FLB_ACTIVE] = cond.flb_active;
    img_d[RDIAG_BIT_FLB_ERR]    = cond.flb_err;
    img_d[RDIAG_BIT_PSU_IN]     = cond.psu_in_fail;
    img_d[RDIAG_BIT_PSU_OUT]    = cond.psu_out_fail;
    img_d[RDIAG_BIT_ADDR_JMP]   = jmp_q;
    img_d[RDIAG_BIT_WR_LOCK]    = cond.wr_lock;
    img_d[RDIAG_BIT_BI_SIM +: 8]   = pair_or16(cond.bi_sim);
    img_d[RDIAG_BIT_BI_FSAFE +: 8] = pair_or16(cond.bi_fsafe);
    img_d[RDIAG_BIT_BO_FSAFE +: 4] = pair_or8(cond.bo_fsafe);
    img_d[RDIAG_BIT_BO_SIM +: 4]   = pair_or8(cond.bo_sim);
    img_d[RDIAG_BIT_BI_OOS +: 8]   = pair_or16(cond.bi_oos);
    img_d[RDIAG_BIT_BO_OOS +: 8]   = cond.bo_oos;
    // appear/disappear events come from the register below, not from levels
    any_err = cond.ident_viol | cond.flb_err | cond.psu_in_fail | cond.psu_out_fail;
  end

  // error edge tracking for the appear and disappear bits
  // the pulses themselves are written into the image register below
  logic err_q;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      err_q <= 1'b0;
    else
      err_q <= any_err;
  end

  // registered image; levels follow conditions one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      diag_img <= '0;
    else
    begin
      diag_img <= img_d;
      diag_img[RDIAG_BIT_ERR_APPEAR] <= any_err & ~err_q;
      diag_img[RDIAG_BIT_ERR_GONE]   <= ~any_err & err_q;
    end
  end

  // extension bit is always set so the length is the extended one from the first cycle after reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      status_len <= RDIAG_LEN_STD;
    else
      status_len <= img_d[RDIAG_BIT_EXT_AVAIL] ? RDIAG_LEN_EXT : RDIAG_LEN_STD;
  end

  // byte-wise read view, byte i carries bits 8i..8i+7 ascending
  logic [RDIAG_NUM_BYTES*8-1:0] img_bytes;
  logic [3:0]                   mem_idx;
  logic [7:0]                   mem_rd;
  assign img_bytes = diag_img[103:RDIAG_FIRST_BYTE*8];
  assign mem_idx   = diag_rd_idx - 4'(RDIAG_FIRST_BYTE);

  rdiag_img_mem #(
    .NBYTES (RDIAG_NUM_BYTES)
  ) u_mem (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .img     (img_bytes),
    .rd_idx  (mem_idx),
    .rd_data (mem_rd)
  );
  assign diag_byte = mem_rd;

  // identifier: active value caught at reset release, stored value by request
  typedef enum {ID_IDLE, ID_SAVE} rdiag_idst_e;
  rdiag_idst_e id_st_q;
  logic        stored_q;
  logic        req_q;
  logic [25:0] save_cnt_q;
  logic        caught_q;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      id_st_q    <= ID_IDLE;
      req_q      <= 1'b0;
      save_cnt_q <= '0;
      id_saving  <= 1'b0;
    end
    else
    begin
      req_q <= id_sel_req;
      case (id_st_q)
        ID_IDLE:
        begin
          if (caught_q && id_sel_req != req_q)
          begin
            id_st_q    <= ID_SAVE;
            save_cnt_q <= 26'(RDIAG_SAVE_CYC - 1);
            id_saving  <= 1'b1;
          end
        end
        ID_SAVE:
        begin
          if (save_cnt_q == '0)
          begin
            id_st_q   <= ID_IDLE;
            id_saving <= 1'b0;
          end
          else
            save_cnt_q <= save_cnt_q - 26'd1;
        end
        default: id_st_q <= ID_IDLE;
      endcase
    end
  end

  // stored selection follows the request until caught and updates at end of save; active one only after reset
  always_ff @(posedge ref_clk)
  begin
    if (id_st_q == ID_SAVE && save_cnt_q == '0)
      stored_q <= req_q;
    else if (!caught_q)
      stored_q <= id_sel_req;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      caught_q  <= 1'b0;
      id_active <= 1'b0;
    end
    else if (!caught_q)
    begin
      caught_q  <= 1'b1;
      id_active <= stored_q;
    end
  end

  // cyclic refused on identifier mismatch in profile mode, acyclic always served
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cyc_grant  <= 1'b0;
      acyc_grant <= 1'b0;
    end
    else
    begin
      cyc_grant  <= cyc_req & ~(id_active == RDIAG_ID_PROFILE && master_manuf_id);
      acyc_grant <= acyc_req;
    end
  end

  // outputs show the address pattern until init is done when jumper fitted;
  // loads are not isolated here, the operator must disconnect them
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      dout <= RDIAG_DOUT_RST;
    else if (!init_done && jmp_q)
      dout <= {id_active, node_addr};
    else
      dout <= dout_app;
  end

  // checks
  a_ext_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(!sys_rst) |-> status_len == RDIAG_LEN_EXT && diag_img[55])
    else $error("extension bit or length wrong");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    diag_img[54:40] == '0 && !diag_img[38] && !diag_img[62])
    else $error("unused bit set");
  a_restart_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cond.restart |=> diag_img[35])
    else $error("restart bit missing");
  a_bi_sim_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cond.bi_sim[3] | cond.bi_sim[2]) |=> diag_img[65])
    else $error("input sim pair bit missing");
  a_bo_oos_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cond.bo_oos[7] |=> diag_img[103])
    else $error("output oos bit missing");
  a_flag_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cond.psu_out_fail |=> !diag_img[60])
    else $error("supply flag stuck");
  a_err_appear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(any_err) |=> diag_img[16] ##1 !diag_img[16])
    else $error("appear pulse wrong");
  a_addr_show: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!init_done && jmp_q) |=> dout[6:0] == $past(node_addr))
    else $error("address not shown");
  a_cyc_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (id_active == 1'b0 && master_manuf_id) |=> !cyc_grant)
    else $error("cyclic not refused");
  a_id_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    caught_q |=> $stable(id_active))
    else $error("identifier changed without reset");
  a_cyc_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cyc_req && (id_active || !master_manuf_id)) |=> cyc_grant)
    else $error("cyclic refused without mismatch");
  a_acyc_serve: assert property (@(posedge ref_clk) disable iff (sys_rst)
    acyc_req |=> acyc_grant)
    else $error("acyclic not served");

  c_addr_show:  cover property (@(posedge ref_clk) !init_done && jmp_q && dout[7]);
  c_save_start: cover property (@(posedge ref_clk) $rose(id_saving));
  c_cyc_refuse: cover property (@(posedge ref_clk) cyc_req && master_manuf_id && !id_active);
  c_err_gone:   cover property (@(posedge ref_clk) diag_img[17]);
  c_err_appear: cover property (@(posedge ref_clk) diag_img[16]);
endmodule : rdiag_top
`default_nettype wire

// >>> verification/rdiag_master_model.sv
// cyclic master model: polls every diagnostic byte and holds request levels
// assumes the block's ref_clk domain and its synchronous reset
`default_nettype none
module rdiag_master_model (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         want_cyc,
  input  wire logic         want_acyc,
  input  wire logic [7:0]   diag_byte,
  output logic              cyc_req,
  output logic              acyc_req,
  output logic [3:0]        diag_rd_idx,
  output logic [127:0]      rx_img
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] slot_q;

  // four cycles per byte cover the one-cycle read latency with three to spare
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      slot_q      <= 2'h0;
      diag_rd_idx <= 4'h0;
    end
    else
    begin
      slot_q <= slot_q + 2'h1;
      if (slot_q == 2'h3)
      begin
        rx_img[diag_rd_idx*8 +: 8] <= diag_byte;
        diag_rd_idx                <= diag_rd_idx + 4'h1;
      end
    end
  end

  // request levels, registered; requests clear on the same edge as the block's synchronous reset
  always_ff @(posedge ref_clk)
  begin
    cyc_req  <= want_cyc & ~sys_rst;
    acyc_req <= want_acyc & ~sys_rst;
  end
endmodule : rdiag_master_model
`default_nettype wire

// >>> verification/test_rdiag_top.sv
// testbench for the diagnostic image and address display block
// assumes the master model beside it; the 5 s save is only seen starting
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module test_rdiag_top;
  import rdiag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          ref_clk, sys_rst, sim_jumper_pin, id_sel_req, init_done;
  logic          master_manuf_id, cyc_req, acyc_req, want_cyc, want_acyc;
  logic          id_active, id_saving, cyc_grant, acyc_grant, jmp, id_exp;
  rdiag_cond_s   cond, c;
  logic [6:0]    node_addr;
  logic [3:0]    diag_rd_idx;
  logic [7:0]    dout_app, dout, diag_byte, status_len;
  logic [103:0]  diag_img, e;
  logic [127:0]  rx_img;
  int            checks, mismatches, seed, i, n16, n17;

  rdiag_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cond(cond),
    .sim_jumper_pin(sim_jumper_pin), .node_addr(node_addr), .id_sel_req(id_sel_req),
    .init_done(init_done), .diag_rd_idx(diag_rd_idx), .master_manuf_id(master_manuf_id),
    .cyc_req(cyc_req), .acyc_req(acyc_req), .dout_app(dout_app), .dout(dout),
    .diag_img(diag_img), .diag_byte(diag_byte), .status_len(status_len),
    .id_active(id_active), .id_saving(id_saving), .cyc_grant(cyc_grant),
    .acyc_grant(acyc_grant));

  rdiag_master_model master (.ref_clk(ref_clk), .sys_rst(sys_rst), .want_cyc(want_cyc),
    .want_acyc(want_acyc), .diag_byte(diag_byte), .cyc_req(cyc_req),
    .acyc_req(acyc_req), .diag_rd_idx(diag_rd_idx), .rx_img(rx_img));

  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // expected image from condition levels; pairs of blocks share one flag, except output out of service
  function automatic logic [103:0] exp_img(input rdiag_cond_s k);
    logic [103:0] x;
    x = '0;
    x[35] = k.restart;
    x[36] = k.coldstart;
    x[37] = k.maint_req;
    x[39] = k.ident_viol;
    x[55] = 1'b1;
    x[56] = k.tb_oos;
    x[57] = k.flb_active;
    x[58] = k.flb_err;
    x[59] = k.psu_in_fail;
    x[60] = k.psu_out_fail;
    x[61] = k.addr_jumper;
    x[63] = k.wr_lock;
    for (int j = 0; j < 8; j++)
    begin
      x[64+j] = |k.bi_sim[2*j +: 2];
      x[72+j] = |k.bi_fsafe[2*j +: 2];
      x[88+j] = |k.bi_oos[2*j +: 2];
      x[96+j] = k.bo_oos[j];
      if (j < 4)
      begin
        x[80+j] = |k.bo_fsafe[2*j +: 2];
        x[84+j] = |k.bo_sim[2*j +: 2];
      end
    end
    return x;
  endfunction : exp_img

  // counts the one-cycle appear and disappear pulses over eight cycles
  task automatic count_pulses;
    n16 = 0;
    n17 = 0;
    repeat (8)
    begin
      @(negedge ref_clk);
      n16 += int'(diag_img[16] === 1'b1);
      n17 += int'(diag_img[17] === 1'b1);
    end
  endtask : count_pulses

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // a hang past three times the expected run length ends the test
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    seed = 72955;
    id_exp = 1'b0;
    sys_rst = 1'b1;
    cond = '0;
    sim_jumper_pin = 1'b0;
    node_addr = 7'h00;
    id_sel_req = 1'b0;
    init_done = 1'b0;
    dout_app = 8'h00;
    master_manuf_id = 1'b0;
    want_cyc = 1'b0;
    want_acyc = 1'b0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(status_len, 8'h08)
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    // first two passes clear and set every condition except the address jumper, which stays random
    for (i = 0; i < 42; i++)
    begin
      @(posedge ref_clk);
      c = 83'({$random(seed), $random(seed), $random(seed)});
      if (i == 0)
        c = '0;
      if (i == 1)
        c = '1;
      jmp = 1'($random(seed));
      c.addr_jumper = jmp;
      e = exp_img(c);
      cond <= c;
      sim_jumper_pin <= jmp;
      node_addr <= 7'($random(seed));
      init_done <= 1'($random(seed));
      dout_app <= 8'($random(seed));
      master_manuf_id <= 1'($random(seed));
      want_cyc <= 1'($random(seed));
      want_acyc <= 1'($random(seed));
      // two full polling sweeps so every byte is fresh
      repeat (140) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(diag_img, e)
      `CHK(rx_img, {24'h0, e})
      `CHK(status_len, 8'h0e)
      if (!init_done && jmp)
        `CHK(dout, {id_exp, node_addr})
      else
        `CHK(dout, dout_app)
      `CHK(cyc_grant, want_cyc & ~(~id_exp & master_manuf_id))
      `CHK(acyc_grant, want_acyc)
    end
    // error appears then disappears on the output supply
    @(posedge ref_clk);
    cond <= '0;
    repeat (10) @(posedge ref_clk);
    cond.psu_out_fail <= 1'b1;
    count_pulses();
    `CHK(n16, 1)
    `CHK(n17, 0)
    @(posedge ref_clk);
    cond.psu_out_fail <= 1'b0;
    count_pulses();
    `CHK(n16, 0)
    `CHK(n17, 1)
    // identifier change starts the save and leaves the running identifier alone
    @(posedge ref_clk);
    id_sel_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(id_saving, 1'b1)
    `CHK(id_active, id_exp)
    // loads cleared before a reset with the jumper fitted; the new selection
    // must then show on output 8 and lift the cyclic refusal
    @(posedge ref_clk);
    dout_app <= 8'h00;
    sim_jumper_pin <= 1'b1;
    init_done <= 1'b0;
    // the tool reaches the unit at its present address before moving it
    node_addr <= 7'($random(seed));
    master_manuf_id <= 1'b1;
    want_cyc <= 1'b1;
    want_acyc <= 1'b1;
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(status_len, RDIAG_LEN_STD)
    `CHK(dout, RDIAG_DOUT_RST)
    `CHK(cyc_grant, 1'b0)
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    id_exp = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(id_active, id_exp)
    `CHK(status_len, RDIAG_LEN_EXT)
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(dout, {id_exp, node_addr})
    `CHK(cyc_grant, want_cyc)
    `CHK(acyc_grant, want_acyc)
    end_sim();
  end
endmodule : test_rdiag_top
`default_nettype wire
